// ===== hdl/psfr_map.vh
// Purpose: Constants for the power stage fault and reset control block
// Assumes: One 10 MHz clock, registers reached over Avalon-MM
// Notes: Byte offsets, field positions and reset values
`ifndef PSFR_MAP_VH
`define PSFR_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PSFR_CTRL_OFS 4'h0
`define PSFR_STAT_OFS 4'h4
`define PSFR_EVT_OFS 4'h8
`define PSFR_MASK_OFS 4'hc

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PSFR_CTRL_BRIDGED 0
`define PSFR_CTRL_RST 1'b1

// ----------------------------------------
// Status fields
// ----------------------------------------
`define PSFR_ST_UV 0
`define PSFR_ST_POR 1
`define PSFR_ST_OL1 2
`define PSFR_ST_OL2 3
`define PSFR_ST_OT 4
`define PSFR_ST_SD 5
`define PSFR_ST_WARN 6

// ----------------------------------------
// Event bits, same layout for mask
// ----------------------------------------
`define PSFR_EV_UV 0
`define PSFR_EV_OL1 1
`define PSFR_EV_OL2 2
`define PSFR_EV_OT 3
`define PSFR_EV_WARN 4
`define PSFR_EV_W 5
`define PSFR_MASK_RST 5'h00

`endif

// ===== hdl/psfr_edge_det.v
// Purpose: Rising edge detector for one reset input
// Assumes: Input synchronous to ref_clk
// Notes: Combinational pulse in the same cycle as the low-to-high step
`timescale 1ns/1ps
module psfr_edge_det (
  ref_clk,
  sys_rst,
  level_in,
  rise_pulse
);
  input wire ref_clk;
  input wire sys_rst;
  input wire level_in;
  output wire rise_pulse;

  reg last_reg;

  // Starts high so a reset input already high at power up gives no false edge
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_reg <= 1'b1;
    end else begin
      last_reg <= level_in;
    end
  end

  assign rise_pulse = level_in & ~last_reg;
endmodule

// ===== hdl/psfr_ctrl.v
// Purpose: Fault latching, reset handling and flag encoding for a
//   four half-bridge power stage, with an Avalon-MM register slave
// Assumes: All inputs synchronous to ref_clk; supply good inputs are
//   comparator levels from the analog side
// Notes: Hi-Z enables are active high per half-bridge
// Contract
// - At power-up clear overload latches, hold outputs off until supplies good.
// - Any supply under threshold: all bridges Hi-Z at once, shutdown flag low.
// - Undervoltage recovers by itself once every supply is good again.
// - First pair reset low forces both transistors of bridges A, B off.
// - Second pair reset low forces bridges C, D off, independently.
// - Bridged mode: reset low switches on weak pulldown for that pair.
// - Single-ended mode: no weak pulldown while reset is low.
// - Either reset low forces shutdown flag high, hiding any fault.
// - Reset rising edge releases a latched overload shutdown.
// - Flags encode overload/UV, overtemperature and warning as tabled.
// - Overtemperature latched; cleared only once both resets were asserted.
// - Overload latched separately for pair A/B and pair C/D.
`timescale 1ns/1ps
`include "psfr_map.vh"
module psfr_ctrl (
  ref_clk,
  sys_rst,
  pair_one_hold_n,
  pair_two_hold_n,
  gate_drive_supply_good,
  logic_supply_good,
  overload_one,
  overload_two,
  overtemp_trip,
  temp_warning,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  bridge_hiz,
  weak_pulldown,
  fault_shutdown_flag_n,
  thermal_warning_flag_n,
  irq
);
  input wire ref_clk;
  input wire sys_rst;
  input wire pair_one_hold_n;
  input wire pair_two_hold_n;
  input wire gate_drive_supply_good;
  input wire logic_supply_good;
  input wire overload_one;
  input wire overload_two;
  input wire overtemp_trip;
  input wire temp_warning;
  input wire [3:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output wire avs_waitrequest;
  output reg [3:0] bridge_hiz;
  output reg [3:0] weak_pulldown;
  output reg fault_shutdown_flag_n;
  output reg thermal_warning_flag_n;
  output wire irq;

  // ----------------------------------------
  // Power-on sequencer states
  // ----------------------------------------
  localparam [2:0] ST_POR = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_UV = 3'h4;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg overload_latch_one_reg;
  reg overload_latch_two_reg;
  reg overtemp_shutdown_latch_reg;
  reg ot_seen_one_reg;
  reg ot_seen_two_reg;
  reg bridged_load_config_reg;
  reg [`PSFR_EV_W-1:0] evt_reg;
  reg [`PSFR_EV_W-1:0] mask_reg;
  reg [`PSFR_EV_W-1:0] evt_set;
  reg ack_reg;
  reg uv_prev_reg;
  reg warn_prev_reg;
  wire supply_undervoltage_guard;
  wire rise_one;
  wire rise_two;
  wire single_ended_config;
  wire [1:0] hold_n;
  wire [1:0] pair_off;
  wire any_fault;
  wire common_off;
  wire rd_evt;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function addr_hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Shared shutdown terms plus the pair's own latch and reset level
  function pair_blocked;
    input shared_off;
    input latch;
    input hold_level_n;
    begin
      pair_blocked = shared_off | latch | ~hold_level_n;
    end
  endfunction

  assign supply_undervoltage_guard =
    ~(gate_drive_supply_good & logic_supply_good);
  assign single_ended_config = ~bridged_load_config_reg;
  assign hold_n = {pair_two_hold_n, pair_one_hold_n};

  // ----------------------------------------
  // Reset edge detection per pair
  // ----------------------------------------
  psfr_edge_det u_edge_one (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .level_in(pair_one_hold_n),
    .rise_pulse(rise_one)
  );
  psfr_edge_det u_edge_two (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .level_in(pair_two_hold_n),
    .rise_pulse(rise_two)
  );

  // ----------------------------------------
  // Supply sequencer
  // ----------------------------------------
  always @* begin
    case (state_reg)
      ST_POR: begin
        if (!supply_undervoltage_guard) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_POR;
        end
      end
      ST_RUN: begin
        if (supply_undervoltage_guard) begin
          state_next = ST_UV;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_UV: begin
        if (!supply_undervoltage_guard) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_UV;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Fault latches
  // ----------------------------------------
  // Set wins over the edge clear: a persisting overload relatches
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overload_latch_one_reg <= 1'b0;
      overload_latch_two_reg <= 1'b0;
    end else if (state_reg == ST_POR) begin
      overload_latch_one_reg <= 1'b0;
      overload_latch_two_reg <= 1'b0;
    end else begin
      if (overload_one) begin
        overload_latch_one_reg <= 1'b1;
      end else if (rise_one) begin
        overload_latch_one_reg <= 1'b0;
      end
      if (overload_two) begin
        overload_latch_two_reg <= 1'b1;
      end else if (rise_two) begin
        overload_latch_two_reg <= 1'b0;
      end
    end
  end

  // Both resets must have been low since the trip, in either order
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overtemp_shutdown_latch_reg <= 1'b0;
      ot_seen_one_reg <= 1'b0;
      ot_seen_two_reg <= 1'b0;
    end else if (overtemp_trip) begin
      overtemp_shutdown_latch_reg <= 1'b1;
      ot_seen_one_reg <= 1'b0;
      ot_seen_two_reg <= 1'b0;
    end else if (overtemp_shutdown_latch_reg) begin
      if ((ot_seen_one_reg | ~pair_one_hold_n) &
          (ot_seen_two_reg | ~pair_two_hold_n)) begin
        overtemp_shutdown_latch_reg <= 1'b0;
        ot_seen_one_reg <= 1'b0;
        ot_seen_two_reg <= 1'b0;
      end else begin
        ot_seen_one_reg <= ot_seen_one_reg | ~pair_one_hold_n;
        ot_seen_two_reg <= ot_seen_two_reg | ~pair_two_hold_n;
      end
    end
  end

  // ----------------------------------------
  // Power stage controls and flags
  // ----------------------------------------
  // Undervoltage acts on the raw comparator; only the output register adds a cycle
  assign common_off = supply_undervoltage_guard |
    (state_reg != ST_RUN) | overtemp_shutdown_latch_reg;
  assign pair_off[0] = pair_blocked(common_off, overload_latch_one_reg,
    pair_one_hold_n);
  assign pair_off[1] = pair_blocked(common_off, overload_latch_two_reg,
    pair_two_hold_n);
  assign any_fault = common_off | overload_latch_one_reg |
    overload_latch_two_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pair
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          bridge_hiz[2*g+1:2*g] <= 2'h3;
          weak_pulldown[2*g+1:2*g] <= 2'h0;
        end else begin
          bridge_hiz[2*g+1:2*g] <= {2{pair_off[g]}};
          // Pulldown only in bridged mode
          weak_pulldown[2*g+1:2*g] <=
            {2{~hold_n[g] & ~single_ended_config}};
        end
      end
    end
  endgenerate

  // Open-drain flags modelled as levels; low means asserted
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_shutdown_flag_n <= 1'b1;
      thermal_warning_flag_n <= 1'b1;
    end else begin
      fault_shutdown_flag_n <= ~(any_fault & pair_one_hold_n &
        pair_two_hold_n);
      thermal_warning_flag_n <= ~(temp_warning |
        overtemp_shutdown_latch_reg);
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  assign rd_evt = avs_read & ~ack_reg & addr_hit(avs_address, `PSFR_EVT_OFS);

  always @* begin
    evt_set = {`PSFR_EV_W{1'b0}};
    evt_set[`PSFR_EV_UV] = supply_undervoltage_guard & ~uv_prev_reg;
    evt_set[`PSFR_EV_OL1] = overload_one & ~overload_latch_one_reg;
    evt_set[`PSFR_EV_OL2] = overload_two & ~overload_latch_two_reg;
    evt_set[`PSFR_EV_OT] = overtemp_trip & ~overtemp_shutdown_latch_reg;
    evt_set[`PSFR_EV_WARN] = temp_warning & ~warn_prev_reg;
  end

  // Set wins over the read clear
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_reg <= {`PSFR_EV_W{1'b0}};
      uv_prev_reg <= 1'b0;
      warn_prev_reg <= 1'b0;
    end else begin
      uv_prev_reg <= supply_undervoltage_guard;
      warn_prev_reg <= temp_warning;
      if (rd_evt) begin
        evt_reg <= evt_set;
      end else begin
        evt_reg <= evt_reg | evt_set;
      end
    end
  end

  assign irq = |(evt_reg & mask_reg);

  // ----------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      bridged_load_config_reg <= `PSFR_CTRL_RST;
      mask_reg <= `PSFR_MASK_RST;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_write & ~ack_reg) begin
        if (addr_hit(avs_address, `PSFR_CTRL_OFS)) begin
          bridged_load_config_reg <= avs_writedata[`PSFR_CTRL_BRIDGED];
        end else if (addr_hit(avs_address, `PSFR_MASK_OFS)) begin
          mask_reg <= avs_writedata[`PSFR_EV_W-1:0];
        end
      end
      if (avs_read & ~ack_reg) begin
        case (avs_address)
          `PSFR_CTRL_OFS:
            avs_readdata <= {31'h0, bridged_load_config_reg};
          `PSFR_STAT_OFS:
            avs_readdata <= {25'h0, ~thermal_warning_flag_n,
              ~fault_shutdown_flag_n, overtemp_shutdown_latch_reg,
              overload_latch_two_reg, overload_latch_one_reg,
              state_reg == ST_POR, supply_undervoltage_guard};
          `PSFR_EVT_OFS:
            avs_readdata <= {27'h0, evt_reg};
          `PSFR_MASK_OFS:
            avs_readdata <= {27'h0, mask_reg};
          default:
            avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ===== testbench/psfr_ctrl_monitor.sv
// Purpose: Port checks for the power stage fault and reset control
// Assumes: One clock domain, reset active high
// Notes: Latency ranges allow for the registered pair-off stage
`timescale 1ns/1ps
module psfr_ctrl_monitor (
  input wire ref_clk,
  input wire sys_rst,
  input wire pair_one_hold_n,
  input wire pair_two_hold_n,
  input wire gate_drive_supply_good,
  input wire logic_supply_good,
  input wire overload_one,
  input wire overtemp_trip,
  input wire temp_warning,
  input wire [3:0] bridge_hiz,
  input wire fault_shutdown_flag_n,
  input wire thermal_warning_flag_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire uv = !(gate_drive_supply_good && logic_supply_good);
  wire up = pair_one_hold_n && pair_two_hold_n;
  wire ab_ok = pair_one_hold_n && !overload_one && !uv && !overtemp_trip;
  sequence s_ol;
    overload_one && pair_one_hold_n ##1 pair_one_hold_n [*3];
  endsequence
  // Warn flag high rules out a latched overtemperature on this pair
  sequence s_rel;
    $rose(pair_one_hold_n) && !uv ##1 (ab_ok && thermal_warning_flag_n) [*4];
  endsequence
  property p_uv_hiz; uv |-> ##[1:3] bridge_hiz == 4'hf; endproperty
  a_uv_hiz: assert property (p_uv_hiz) else $error("supply low, on");
  property p_uv_sd; (uv && up) [*3] |-> !fault_shutdown_flag_n; endproperty
  a_uv_sd: assert property (p_uv_sd) else $error("sd not low");
  property p_one; !pair_one_hold_n |-> ##[1:3] &bridge_hiz[1:0]; endproperty
  a_one: assert property (p_one) else $error("pair one on");
  property p_two; !pair_two_hold_n |-> ##[1:3] &bridge_hiz[3:2]; endproperty
  a_two: assert property (p_two) else $error("pair two on");
  property p_sd_hi; (!up) [*3] |-> fault_shutdown_flag_n; endproperty
  a_sd_hi: assert property (p_sd_hi) else $error("sd low in reset");
  property p_warn; temp_warning [*3] |-> !thermal_warning_flag_n; endproperty
  a_warn: assert property (p_warn) else $error("warn flag high");
  property p_ol; s_ol |-> &bridge_hiz[1:0]; endproperty
  a_ol: assert property (p_ol) else $error("overload not latched");
  property p_rel; s_rel |-> bridge_hiz[1:0] == 2'h0; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_ot; overtemp_trip ##1 up [*4] |-> bridge_hiz == 4'hf
    && !thermal_warning_flag_n && !fault_shutdown_flag_n; endproperty
  a_ot: assert property (p_ot) else $error("thermal latch lost");
endmodule
bind psfr_ctrl psfr_ctrl_monitor u_mon (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .pair_one_hold_n(pair_one_hold_n),
  .pair_two_hold_n(pair_two_hold_n),
  .gate_drive_supply_good(gate_drive_supply_good),
  .logic_supply_good(logic_supply_good), .overload_one(overload_one),
  .overtemp_trip(overtemp_trip), .temp_warning(temp_warning),
  .bridge_hiz(bridge_hiz), .fault_shutdown_flag_n(fault_shutdown_flag_n),
  .thermal_warning_flag_n(thermal_warning_flag_n));

// ===== testbench/psfr_ctrl_model.sv
// Purpose: Controller model driving the two pair reset inputs
// Assumes: Restart requests are one-cycle pulses
// Notes: WAIT_CYC stands in for the one-second restart wait
`timescale 1ns/1ps
module psfr_ctrl_model #(
  parameter int WAIT_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic single_ended,
  input wire logic [1:0] hold_req,
  input wire logic [1:0] restart,
  output logic [1:0] hold_n,
  output logic [1:0] pwm_low,
  output logic busy
);
  int cnt [2];
  logic [1:0] pulse;
  assign hold_n = ~(hold_req | pulse);
  assign busy = (cnt[0] != 0) || (cnt[1] != 0);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pulse[i] = cnt[i] == 2 || cnt[i] == 3;
      pwm_low[i] = single_ended && cnt[i] == 1;
    end
  end
  always @(posedge ref_clk or posedge sys_rst) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst) cnt[i] <= 0;
      else if (restart[i]) cnt[i] <= WAIT_CYC + 3;
      else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
    end
  end
endmodule

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the fault and reset control block
// Assumes: Design and controller model share ref_clk
// Notes: Snapshot is irq, warn_n, sd_n, pulldown, hiz
`timescale 1ns/1ps
`include "psfr_map.vh"
module tb;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic gsup = 0, lsup = 0, ol1 = 0, ot = 0, tw = 0;
  logic rd = 0, wr = 0, look = 0, se = 0;
  logic [3:0] adr = '0;
  logic [31:0] wd = '0;
  logic [1:0] req = '0, go = '0;
  wire [1:0] hold_n;
  wire [31:0] rdat;
  wire [3:0] hiz, pd;
  wire wait_r, irq, sd_n, tw_n, busy;
  int fails = 0, check_count = 0, cyc = 0;
  logic [31:0] rq [$];
  logic [10:0] oq [$];
  always #50 ref_clk = ~ref_clk;
  psfr_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pair_one_hold_n(hold_n[0]), .pair_two_hold_n(hold_n[1]),
    .gate_drive_supply_good(gsup), .logic_supply_good(lsup),
    .overload_one(ol1), .overload_two(1'h0), .overtemp_trip(ot),
    .temp_warning(tw), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .bridge_hiz(hiz), .weak_pulldown(pd), .fault_shutdown_flag_n(sd_n),
    .thermal_warning_flag_n(tw_n), .irq(irq));
  psfr_ctrl_model #(.WAIT_CYC(20)) u_ctl (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .single_ended(se), .hold_req(req), .restart(go),
    .hold_n(hold_n), .pwm_low(), .busy(busy));
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rd && !wait_r) cmp("readdata", rq.pop_front(), rdat);
    if (look) cmp("ports", {21'h0, oq.pop_front()},
      {21'h0, irq, tw_n, sd_n, pd, hiz});
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge ref_clk); while (wait_r);
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rdx(logic [3:0] a, logic [31:0] e);
    rq.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic chk(logic [10:0] e);
    repeat (4) @(posedge ref_clk);
    oq.push_back(e);
    look <= 1'h1;
    @(posedge ref_clk);
    look <= 1'h0;
  endtask
  task automatic restart(logic [1:0] p);
    go <= p;
    @(posedge ref_clk);
    go <= 2'h0;
    repeat (2) @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
  endtask
  initial begin
    int r;
    logic [3:0] e;
    r = $urandom(2574);
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    chk(11'h20f);
    gsup <= 1'h1;
    lsup <= 1'h1;
    chk(11'h300);
    rdx(`PSFR_CTRL_OFS, 32'h1);
    rdx(`PSFR_MASK_OFS, 32'h0);
    bus(1'h1, `PSFR_STAT_OFS, $urandom);
    rdx(`PSFR_STAT_OFS, 32'h0);
    rdx(4'h2, 32'h0);
    bus(1'h1, `PSFR_MASK_OFS, 32'hffffffff);
    rdx(`PSFR_MASK_OFS, 32'h1f);
    $display("end of test: registers");
    if ($urandom % 2 == 1) gsup <= 1'h0;
    else lsup <= 1'h0;
    chk(11'h60f);
    req <= 2'h1;
    chk(11'h73f);
    req <= 2'h0;
    rdx(`PSFR_EVT_OFS, 32'h1);
    chk(11'h20f);
    gsup <= 1'h1;
    lsup <= 1'h1;
    chk(11'h300);
    $display("end of test: undervoltage");
    for (int m = 0; m < 2; m++) begin
      bus(1'h1, `PSFR_CTRL_OFS, 32'(m));
      se <= (m == 0);
      for (int k = 1; k < 4; k++) begin
        req <= 2'(k);
        e = {{2{k[1]}}, {2{k[0]}}};
        chk({3'h3, m[0] ? e : 4'h0, e});
      end
    end
    req <= 2'h0;
    $display("end of test: pair resets");
    req <= 2'h2;
    ol1 <= 1'h1;
    chk(11'h7cf);
    req <= 2'h0;
    ol1 <= 1'h0;
    chk(11'h603);
    rdx(`PSFR_EVT_OFS, 32'h2);
    restart(2'h1);
    chk(11'h300);
    $display("end of test: overload");
    ot <= 1'h1;
    chk(11'h40f);
    ot <= 1'h0;
    restart(2'h1);
    chk(11'h40f);
    restart(2'h2);
    chk(11'h700);
    rdx(`PSFR_EVT_OFS, 32'h8);
    $display("end of test: overtemperature");
    bus(1'h1, `PSFR_MASK_OFS, 32'hf);
    tw <= 1'h1;
    chk(11'h100);
    tw <= 1'h0;
    rdx(`PSFR_EVT_OFS, 32'h10);
    chk(11'h300);
    $display("end of test: warning");
    close_out();
  end
endmodule
